// ==== hw/spi_chain_pkg.sv ====
// Shared constants and state types for the chained serial link
package spi_chain_pkg;

  // ----------------------------------------------------------------
  // Packet layout
  // ----------------------------------------------------------------
  localparam int BYTE_W = 8;
  localparam int CID_W = 5;
  localparam int BCAST_BIT = 7;
  localparam int RW_BIT = 6;
  localparam int RSVD_BIT = 5;
  localparam int CID_TOP_BIT = 4;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // Received-bit count at which the chain position field begins
  localparam logic [3:0] CID_FIRST_CNT = 4'h3;
  localparam logic [3:0] CID_LAST_CNT = 4'h7;
  localparam logic [1:0] LAST_BYTE = 2'h2;
  localparam int REG_COUNT = 4;
  localparam logic [BYTE_W-1:0] REG_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int MCLK_PERIOD_NS = 50;
  localparam int LINK_PERIOD_NS = 400;
  localparam int SCLK_HALF_CYC = LINK_PERIOD_NS / (2 * MCLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DS_CTRL, DS_ADDR, DS_DATA, DS_LOST
  } dev_state_t;

  typedef enum logic [2:0] {
    MS_IDLE, MS_SYNC_H, MS_SYNC_L, MS_SEL, MS_LO, MS_HI, MS_END, MS_DONE
  } mst_state_t;

endpackage : spi_chain_pkg

// ==== hw/spi_chain_if.sv ====
// Link wires between the chain master and one chained device
`timescale 1ns/10ps
`default_nettype none
interface spi_chain_if;
  logic sel_n;
  logic sclk;
  logic mosi;
  logic mosi_oe;
  logic miso;
  logic miso_oe;
  logic chain_data_out;

  modport master (
    output sel_n, sclk, mosi, mosi_oe,
    input miso
  );

  modport device (
    input sel_n, sclk, mosi,
    output miso, miso_oe, chain_data_out
  );
endinterface : spi_chain_if
`default_nettype wire

// ==== hw/spi_chain_device.sv ====
// Chained serial slave: packet decode, register file, chain pass-through
// Function
// [RULE1] Broadcast write updates every device regardless of id
// [RULE2] Unmapped write address changes no register
// [RULE3] Master sends write data as third byte
// [RULE4] Data output stays released throughout any write
// [RULE5] All bits pass through unchanged except id
// [RULE6] Low five control bits carry chain position id
// [RULE7] Id decremented by one bit-serially when passing
// [RULE8] Master sends id bit-reversed, id bit 0 first
// [RULE9] Received id zero means this device is addressed
// [RULE10] Non-broadcast write updates only id-zero device
// [RULE11] Unchained master always sends id zero
// [RULE12] Input to pass-through output is purely combinational
// [RULE13] Master releases shared data wire for read data
// [RULE14] Unchained devices use separate selects, shared data
// [RULE15] Unaddressed device ignores packet, keeps output released
// [RULE16] Eight rising clocks per byte; deselect advances byte
// [RULE17] Clock edge while deselected restarts packet at control
// [RULE18] Bit 6 read, bit 5 zero, broadcast ignored on reads
`timescale 1ns/10ps
`default_nettype none
module spi_chain_device
  import spi_chain_pkg::*;
#(
  parameter int NUM_REGS = REG_COUNT
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  spi_chain_if.device link,
  output logic [NUM_REGS*BYTE_W-1:0] regs_o,
  output logic wr_strobe_o,
  output logic [BYTE_W-1:0] wr_addr_o
);

  localparam int IDX_W = (NUM_REGS > 1) ? $clog2(NUM_REGS) : 1;

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [1:0] sel_s_q;
  logic [1:0] sclk_s_q;
  logic [1:0] mosi_s_q;
  logic sclk_prev_q;
  logic sel_prev_q;

  // Two flops on every pin before the packet logic looks at it; the pass-through uses raw mosi
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      sel_s_q <= 2'h3;
      sclk_s_q <= 2'h0;
      mosi_s_q <= 2'h0;
      sclk_prev_q <= 1'b0;
      sel_prev_q <= 1'b1;
    end else begin
      sel_s_q <= {sel_s_q[0], link.sel_n};
      sclk_s_q <= {sclk_s_q[0], link.sclk};
      mosi_s_q <= {mosi_s_q[0], link.mosi};
      sclk_prev_q <= sclk_s_q[1];
      sel_prev_q <= sel_s_q[1];
    end
  end

  wire sel_n = sel_s_q[1];
  wire mosi_bit = mosi_s_q[1];
  wire sclk_rise = sclk_s_q[1] & ~sclk_prev_q;
  wire sclk_fall = ~sclk_s_q[1] & sclk_prev_q;
  wire sel_release = sel_n & ~sel_prev_q;

  // ----------------------------------------------------------------
  // Packet state
  // ----------------------------------------------------------------
  dev_state_t state_q;
  logic [3:0] bit_cnt_q;
  logic [BYTE_W-1:0] shift_q;
  logic [BYTE_W-1:0] ctrl_q;
  logic [BYTE_W-1:0] addr_q;
  logic borrow_q;
  logic [BYTE_W-1:0] rd_q;
  logic miso_oe_q;
  logic wr_strobe_q;
  logic [BYTE_W-1:0] wr_addr_q;
  logic [BYTE_W-1:0] regs_q [NUM_REGS];

  // Byte framing and decode
  wire full_byte = (bit_cnt_q == BITS_PER_BYTE);
  wire byte_done = sel_release & full_byte; // [RULE16]
  wire byte_short = sel_release & ~full_byte;
  wire extra_clk = sclk_rise & ~sel_n & full_byte;
  wire addressed = (ctrl_q[CID_W-1:0] == '0); // [RULE6] [RULE9]
  wire is_read = ctrl_q[RW_BIT]; // [RULE18]
  wire write_take = ~is_read & (addressed | ctrl_q[BCAST_BIT]); // [RULE1] [RULE10]
  wire read_sel = is_read & addressed; // [RULE18] [RULE15]
  wire addr_ok = (int'(addr_q) < NUM_REGS); // [RULE2]
  wire new_addr_ok = (int'(shift_q) < NUM_REGS);
  wire wr_hit = byte_done & (state_q == DS_DATA) & write_take & addr_ok;
  wire cid_window = (state_q == DS_CTRL) & (bit_cnt_q >= CID_FIRST_CNT) &
                    (bit_cnt_q <= CID_LAST_CNT);
  wire [IDX_W-1:0] wr_idx = addr_q[IDX_W-1:0];
  wire [IDX_W-1:0] rd_idx = shift_q[IDX_W-1:0];
  wire [BYTE_W-1:0] rd_value = new_addr_ok ? regs_q[rd_idx] : '0;
  wire miso_on = (state_q == DS_DATA) & read_sel & ~sel_n;

  // Bit counting, byte sequencing and resynchronisation
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= DS_CTRL;
      bit_cnt_q <= 4'h0;
      shift_q <= '0;
      ctrl_q <= '0;
      addr_q <= '0;
      borrow_q <= 1'b1;
    end else if (sclk_rise & sel_n) begin
      state_q <= DS_CTRL; // [RULE17]
      bit_cnt_q <= 4'h0;
      borrow_q <= 1'b1;
    end else if (extra_clk) begin
      state_q <= DS_LOST; // Ninth clock drops the packet
    end else if (sclk_rise & ~sel_n) begin
      bit_cnt_q <= bit_cnt_q + 4'h1; // [RULE16]
      shift_q <= {shift_q[BYTE_W-2:0], mosi_bit};
      if (cid_window) begin
        borrow_q <= borrow_q & ~mosi_bit; // [RULE7]
      end
    end else if (byte_short) begin
      state_q <= DS_LOST;
      bit_cnt_q <= 4'h0;
    end else if (byte_done) begin
      bit_cnt_q <= 4'h0;
      case (state_q)
        DS_CTRL: begin
          ctrl_q <= shift_q;
          state_q <= DS_ADDR;
        end
        DS_ADDR: begin
          addr_q <= shift_q; // [RULE2]
          state_q <= DS_DATA;
        end
        DS_DATA: begin
          state_q <= DS_CTRL; // [RULE3]
          borrow_q <= 1'b1;
        end
        default: state_q <= DS_LOST;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register file and write strobe
  // ----------------------------------------------------------------
  generate
    for (genvar i = 0; i < NUM_REGS; i++) begin : g_reg
      always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
          regs_q[i] <= REG_RESET;
        end else if (wr_hit && (wr_idx == IDX_W'(i))) begin
          regs_q[i] <= shift_q; // [RULE1] [RULE10] [RULE2]
        end
      end
      assign regs_o[i*BYTE_W +: BYTE_W] = regs_q[i];
    end
  endgenerate

  // One-cycle strobe with the written address
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      wr_strobe_q <= 1'b0;
      wr_addr_q <= '0;
    end else begin
      wr_strobe_q <= wr_hit;
      if (wr_hit) begin
        wr_addr_q <= addr_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data return
  // ----------------------------------------------------------------
  // Load after the address byte, shift on each falling clock
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      rd_q <= '0;
      miso_oe_q <= 1'b0;
    end else begin
      miso_oe_q <= miso_on; // [RULE4] [RULE15]
      if (byte_done && (state_q == DS_ADDR)) begin
        rd_q <= rd_value; // Unmapped reads return zero
      end else if (sclk_fall && miso_on) begin
        rd_q <= {rd_q[BYTE_W-2:0], 1'b0};
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Pass-through stays combinational; only id bits are altered
  assign link.chain_data_out = link.mosi ^ (cid_window & borrow_q); // [RULE5] [RULE7] [RULE12]
  assign link.miso = rd_q[BYTE_W-1];
  assign link.miso_oe = miso_oe_q;
  assign wr_strobe_o = wr_strobe_q;
  assign wr_addr_o = wr_addr_q;

endmodule : spi_chain_device
`default_nettype wire

// ==== hw/spi_chain_master.sv ====
// Chain master: builds three-byte packets and drives the link clock
`timescale 1ns/10ps
`default_nettype none
module spi_chain_master
  import spi_chain_pkg::*;
#(
  parameter int HALF_CYC = SCLK_HALF_CYC
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic start_i,
  input wire logic broadcast_i,
  input wire logic read_i,
  input wire logic [CID_W-1:0] cid_i,
  input wire logic [BYTE_W-1:0] addr_i,
  input wire logic [BYTE_W-1:0] wdata_i,
  spi_chain_if.master link,
  output logic busy_o,
  output logic done_o,
  output logic [BYTE_W-1:0] rdata_o
);

  localparam int PKT_W = 3 * BYTE_W;
  localparam logic [7:0] HALF_LAST = 8'(HALF_CYC - 1);

  // ----------------------------------------------------------------
  // Control byte assembly
  // ----------------------------------------------------------------
  logic [CID_W-1:0] cid_rev;
  generate
    for (genvar i = 0; i < CID_W; i++) begin : g_rev
      assign cid_rev[i] = cid_i[CID_W-1-i]; // [RULE8]
    end
  endgenerate
  // Reserved bit sent as zero; id zero when unchained [RULE11] [RULE18]
  wire [BYTE_W-1:0] ctrl_byte = {broadcast_i & ~read_i, read_i, 1'b0,
                                 cid_rev}; // [RULE6]

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  mst_state_t state_q;
  logic [7:0] div_q;
  logic [3:0] bit_q;
  logic [1:0] byte_q;
  logic [PKT_W-1:0] tx_q;
  logic [BYTE_W-1:0] rx_q;
  logic rd_q;
  logic [1:0] miso_s_q;
  logic sclk_q;
  logic sel_n_q;
  logic mosi_q;
  logic mosi_oe_q;
  logic busy_q;
  logic done_q;
  logic [BYTE_W-1:0] rdata_q;

  wire tick = (div_q == HALF_LAST);
  wire last_bit = (bit_q == BITS_PER_BYTE - 4'h1);
  wire last_byte = (byte_q == LAST_BYTE);

  // Read data pin through two flops
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      miso_s_q <= 2'h0;
      div_q <= 8'h00;
    end else begin
      miso_s_q <= {miso_s_q[0], link.miso};
      div_q <= (tick || state_q == MS_IDLE) ? 8'h00 : div_q + 8'h01;
    end
  end

  // Packet: resync clock, then three framed bytes [RULE16] [RULE17]
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= MS_IDLE;
      bit_q <= 4'h0;
      byte_q <= 2'h0;
      tx_q <= '0;
      rx_q <= '0;
      rd_q <= 1'b0;
      sclk_q <= 1'b0;
      sel_n_q <= 1'b1;
      mosi_q <= 1'b0;
      mosi_oe_q <= 1'b1;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      rdata_q <= '0;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        MS_IDLE: if (start_i) begin
          tx_q <= {ctrl_byte, addr_i, wdata_i}; // [RULE3]
          rd_q <= read_i;
          byte_q <= 2'h0;
          bit_q <= 4'h0;
          busy_q <= 1'b1;
          state_q <= MS_SYNC_H;
        end
        MS_SYNC_H: if (tick) begin
          sclk_q <= 1'b1; // [RULE17]
          state_q <= MS_SYNC_L;
        end
        MS_SYNC_L: if (tick) begin
          sclk_q <= 1'b0;
          state_q <= MS_SEL;
        end
        MS_SEL: if (tick) begin
          sel_n_q <= 1'b0;
          mosi_q <= tx_q[PKT_W-1];
          mosi_oe_q <= ~(rd_q & last_byte); // [RULE13]
          state_q <= MS_LO;
        end
        MS_LO: if (tick) begin
          sclk_q <= 1'b1;
          state_q <= MS_HI;
        end
        MS_HI: if (tick) begin
          sclk_q <= 1'b0;
          rx_q <= {rx_q[BYTE_W-2:0], miso_s_q[1]};
          tx_q <= {tx_q[PKT_W-2:0], 1'b0};
          mosi_q <= tx_q[PKT_W-2];
          bit_q <= last_bit ? 4'h0 : bit_q + 4'h1;
          state_q <= last_bit ? MS_END : MS_LO;
        end
        MS_END: if (tick) begin
          sel_n_q <= 1'b1; // [RULE16]
          mosi_oe_q <= 1'b1;
          byte_q <= byte_q + 2'h1;
          state_q <= last_byte ? MS_DONE : MS_SEL;
        end
        MS_DONE: begin
          done_q <= 1'b1;
          busy_q <= 1'b0;
          rdata_q <= rd_q ? rx_q : '0;
          state_q <= MS_IDLE;
        end
        default: state_q <= MS_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign link.sclk = sclk_q;
  assign link.sel_n = sel_n_q; // [RULE14]
  assign link.mosi = mosi_q;
  assign link.mosi_oe = mosi_oe_q;
  assign busy_o = busy_q;
  assign done_o = done_q;
  assign rdata_o = rdata_q;

endmodule : spi_chain_master
`default_nettype wire

// ==== tb/spi_chain_chk.sv ====
// Link checker for the device fed directly by the master
`timescale 1ns/10ps
`default_nettype none
module spi_chain_chk (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic sel_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso_oe,
  input wire logic chain_data_out
);
  // ----------------------------------------------------------------
  // Packet tracking seen from the link
  // ----------------------------------------------------------------
  logic sclk_q, sel_q, rd_q, brw_q;
  logic [3:0] rcnt_q;
  logic [1:0] byte_q;

  // Link edges and the chain position window
  wire logic sclk_up = sclk & ~sclk_q;
  wire logic sel_fall = ~sel_n & sel_q;
  wire logic byte_end = sel_n & ~sel_q & (rcnt_q == 4'h8);
  wire logic in_cid = (byte_q == 2'h0) & (rcnt_q >= 4'h3) & (rcnt_q <= 4'h7);
  wire logic rise_sel = sclk_up & ~sel_n;

  // Byte, bit, direction and borrow trackers
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      {sclk_q, sel_q, rd_q, brw_q} <= 4'h5;
      rcnt_q <= 4'h0;
      byte_q <= 2'h0;
    end else begin
      sclk_q <= sclk;
      sel_q <= sel_n;
      if (sclk_up & sel_n) byte_q <= 2'h0;
      else if (byte_end) byte_q <= (byte_q == 2'h2) ? 2'h0 : byte_q + 2'h1;
      if (sel_fall) rcnt_q <= 4'h0;
      else if (rise_sel) rcnt_q <= rcnt_q + 4'h1;
      if (rise_sel & (byte_q == 2'h0) & (rcnt_q == 4'h1)) rd_q <= mosi;
      if (sel_fall) brw_q <= 1'h1;
      else if (rise_sel & in_cid) brw_q <= brw_q & ~mosi;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  AST_CTRL_HEAD: assert property (
    !sel_n && byte_q == 2'h0 && rcnt_q < 4'h3 |-> chain_data_out == mosi)
    else $error("control head bit altered on chain output");
  AST_DECR_BIT: assert property (
    $rose(sclk) && !sel_n && in_cid |-> chain_data_out == (mosi ^ brw_q))
    else $error("chain position id not decremented bit-serially");
  AST_BODY_THRU: assert property (
    byte_q != 2'h0 |-> chain_data_out == mosi)
    else $error("address or data bit altered on chain output");
  AST_WRITE_QUIET: assert property (
    !rd_q |-> !miso_oe)
    else $error("data output driven during a write");
  AST_OE_START: assert property (
    $rose(miso_oe) |-> !sel_n && byte_q == 2'h2 && rd_q)
    else $error("data output driven outside a read data byte");
  AST_OE_HOLD: assert property (
    $rose(miso_oe) |-> miso_oe [*8])
    else $error("read data output dropped early");
  AST_OE_BYTE: assert property (
    miso_oe |-> byte_q == 2'h2 || $past(byte_q, 4) == 2'h2)
    else $error("data output driven in a wrong byte");
  AST_OE_IDLE: assert property (
    sel_n [*8] |-> !miso_oe)
    else $error("data output still driven while deselected");
endmodule : spi_chain_chk
`default_nettype wire

// ==== tb/spi_daisy_chain_slave_tb.sv ====
// Testbench: chain master feeding two chained devices
`timescale 1ns/10ps
`default_nettype none
module spi_daisy_chain_slave_tb;
  import spi_chain_pkg::*;
  // ----------------------------------------------------------------
  // Signals, wiring and instances
  // ----------------------------------------------------------------
  typedef struct packed {
    logic bc;
    logic rd;
    logic [4:0] cid;
    logic [7:0] a;
    logic [7:0] d;
  } row_t;
  logic mclk_i = 1'h0;
  logic reset_i = 1'h1;
  logic start = 1'h0, bcast = 1'h0, rdn = 1'h0, busy, done;
  logic [4:0] cid = 5'h00;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic own = 1'h0, t_sel_n = 1'h1, t_sclk = 1'h0, t_mosi = 1'h0;
  logic [31:0] rg [2];
  logic [31:0] e [2] = '{32'h0, 32'h0};
  logic st [2];
  logic [7:0] wa [2];
  int es [2] = '{0, 0};
  int sc [2] = '{0, 0};
  int num_errors = 0;
  int checked = 0;
  row_t rows [12] = '{
    {1'h0, 1'h0, 5'h00, 8'h00, 8'hA5}, {1'h0, 1'h0, 5'h01, 8'h01, 8'h3C},
    {1'h1, 1'h0, 5'h05, 8'h03, 8'h7E}, {1'h0, 1'h0, 5'h00, 8'h04, 8'hFF},
    {1'h0, 1'h0, 5'h02, 8'h02, 8'h55}, {1'h0, 1'h0, 5'h1F, 8'h02, 8'hC3},
    {1'h0, 1'h1, 5'h00, 8'h00, 8'h00}, {1'h0, 1'h1, 5'h01, 8'h01, 8'h00},
    {1'h0, 1'h1, 5'h00, 8'hFF, 8'h00}, {1'h1, 1'h1, 5'h01, 8'h03, 8'h00},
    {1'h0, 1'h0, 5'h00, 8'h03, 8'h81}, {1'h0, 1'h1, 5'h01, 8'h03, 8'h00}};

  always #(MCLK_PERIOD_NS / 2) mclk_i = ~mclk_i;

  spi_chain_if lm ();
  spi_chain_if ld [2] ();
  // Link wiring: pull-ups on released data lines, chain into second device
  assign ld[0].sel_n = own ? t_sel_n : lm.sel_n;
  assign ld[0].sclk = own ? t_sclk : lm.sclk;
  assign ld[0].mosi = own ? t_mosi : (lm.mosi_oe ? lm.mosi : 1'h1);
  assign ld[1].sel_n = ld[0].sel_n;
  assign ld[1].sclk = ld[0].sclk;
  assign ld[1].mosi = ld[0].chain_data_out;
  assign lm.miso = ld[0].miso_oe ? ld[0].miso
                 : (ld[1].miso_oe ? ld[1].miso : 1'h1);

  spi_chain_master #(.HALF_CYC(4)) spi_chain_master_i (
    .mclk_i(mclk_i), .reset_i(reset_i), .start_i(start),
    .broadcast_i(bcast), .read_i(rdn), .cid_i(cid), .addr_i(addr),
    .wdata_i(wdata), .link(lm), .busy_o(busy), .done_o(done),
    .rdata_o(rdata));
  for (genvar k = 0; k < 2; k++) begin : g_dev
    spi_chain_device #(.NUM_REGS(4)) spi_chain_device_i (
      .mclk_i(mclk_i), .reset_i(reset_i), .link(ld[k]), .regs_o(rg[k]),
      .wr_strobe_o(st[k]), .wr_addr_o(wa[k]));
  end
  spi_chain_chk spi_chain_chk_i (
    .mclk_i(mclk_i), .reset_i(reset_i), .sel_n(ld[0].sel_n),
    .sclk(ld[0].sclk), .mosi(ld[0].mosi), .miso_oe(ld[0].miso_oe),
    .chain_data_out(ld[0].chain_data_out));

  // Count write strobes of each device
  always @(posedge mclk_i) begin
    if (st[0] === 1'h1) sc[0]++;
    if (st[1] === 1'h1) sc[1]++;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    checked++;
    if (g !== x) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, g);
    end
  endtask : chk

  task stop_test;
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test

  task chk_regs;
    for (int k = 0; k < 2; k++) begin
      chk("regs", e[k], rg[k]);
      chk("strobes", es[k], sc[k]);
    end
  endtask : chk_regs

  // One packet through the master, with the expected outcome
  task run(input row_t r);
    int n;
    logic [1:0] hit;
    logic [7:0] x;
    for (int k = 0; k < 2; k++) begin
      hit[k] = !r.rd && (r.bc || r.cid == 5'(k)) && r.a < 8'h04;
      if (hit[k]) e[k][8*r.a[1:0] +: 8] = r.d;
      if (hit[k]) es[k]++;
    end
    x = (r.rd && r.cid < 5'h02 && r.a < 8'h04) ? e[r.cid[0]][8*r.a[1:0] +: 8]
      : 8'h00;
    @(negedge mclk_i);
    {bcast, rdn, cid, addr, wdata} = r;
    start = 1'h1;
    @(negedge mclk_i);
    start = 1'h0;
    for (n = 0; n < 20000 && done !== 1'h1; n++) @(negedge mclk_i);
    if (n == 20000) begin
      num_errors++;
      stop_test();
    end
    chk("rdata", {24'h0, x}, {24'h0, rdata});
    repeat (8) @(negedge mclk_i);
    chk_regs();
    for (int k = 0; k < 2; k++)
      if (hit[k]) chk("wr_addr", {24'h0, r.a}, {24'h0, wa[k]});
  endtask : run

  // One byte driven by the bench, with n rising clocks
  task tb_byte(input logic [7:0] b, input int n);
    t_sel_n = 1'h0;
    repeat (4) @(negedge mclk_i);
    for (int i = 0; i < n; i++) begin
      t_mosi = b[7-i];
      repeat (4) @(negedge mclk_i);
      t_sclk = 1'h1;
      repeat (4) @(negedge mclk_i);
      t_sclk = 1'h0;
    end
    repeat (4) @(negedge mclk_i);
    t_sel_n = 1'h1;
    t_mosi = ~t_mosi;
    repeat (8) @(negedge mclk_i);
  endtask : tb_byte

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(negedge mclk_i);
    chk_regs();
    chk("idle", 32'h8, {28'h0, ld[0].sel_n, ld[0].sclk, ld[0].miso_oe, busy});
    reset_i = 1'h0;
    $display("test reset done");
    for (int i = 0; i < 12; i++) run(rows[i]);
    $display("test rows done");
    own = 1'h1;
    tb_byte(8'h10, 8);
    tb_byte(8'h00, 8);
    tb_byte(8'h99, 8);
    e[1][7:0] = 8'h99;
    es[1]++;
    tb_byte(8'h00, 8);
    tb_byte(8'h02, 8);
    tb_byte(8'h11, 5);
    own = 1'h0;
    chk_regs();
    run({1'h0, 1'h0, 5'h00, 8'h02, 8'h66});
    $display("test resync done");
    reset_i = 1'h1;
    repeat (2) @(negedge mclk_i);
    e[0] = 32'h0;
    e[1] = 32'h0;
    chk_regs();
    reset_i = 1'h0;
    run({1'h1, 1'h0, 5'h03, 8'h01, 8'h5A});
    $display("test second reset done");
    stop_test();
  end
endmodule : spi_daisy_chain_slave_tb
`default_nettype wire
